/* File: tb/suca_adapter_properties.sv */
`timescale 1ns/1ps
module suca_adapter_properties (
	input wire       mclk,
	input wire       rst,
	input wire [7:0] src_user_channel_data,
	input wire       src_user_channel_valid,
	input wire       src_user_channel_ready,
	input wire       src_user_channel_clock,
	input wire       frame_timing_clock,
	input wire       frame_timing_start,
	input wire [7:0] src_section_access_data,
	input wire       src_section_access_strobe,
	input wire [7:0] snk_section_access_data,
	input wire       snk_section_access_clock,
	input wire       snk_section_access_frame_start,
	input wire       section_trail_fail,
	input wire [7:0] snk_user_channel_data,
	input wire       snk_user_channel_clock,
	input wire       snk_user_channel_signal_fail
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_fail_raise:
	assert property (section_trail_fail |=> snk_user_channel_signal_fail && snk_user_channel_data == 8'hff) else $error("no fail");
	a_fail_clear:
	assert property ($fell(section_trail_fail) |=> !snk_user_channel_signal_fail) else $error("fail stuck");
	a_user_clock:
	assert property (frame_timing_clock && frame_timing_start |=> src_user_channel_clock) else $error("no user clock");
	a_clock_lone:
	assert property (src_user_channel_clock |=> !src_user_channel_clock [*8]) else $error("user clock repeats");
	a_insert_lone:
	assert property (src_section_access_strobe |=> !src_section_access_strobe [*8]) else $error("strobe repeats");
	a_insert_hold:
	assert property (!src_section_access_strobe |-> $stable(src_section_access_data)) else $error("data moved");
	a_extract_lone:
	assert property (snk_user_channel_clock |=> !snk_user_channel_clock [*8]) else $error("sink clock repeats");
endmodule // suca_adapter_properties
bind suca_adapter suca_adapter_properties chk_u (.*);

/* File: tb/suca_adapter_tb.sv */
`timescale 1ns/1ps
module suca_adapter_tb;
	reg        mclk = 0, rst = 1, src_user_channel_valid = 0, section_trail_fail = 0;
	reg  [7:0] src_user_channel_data = 8'h00, f1_octet = 8'h00;
	wire [7:0] src_section_access_data, snk_section_access_data, snk_user_channel_data;
	wire       src_user_channel_ready, src_user_channel_clock, frame_timing_clock, frame_timing_start;
	wire       src_section_access_strobe, snk_user_channel_clock, snk_user_channel_signal_fail;
	wire       snk_section_access_clock = frame_timing_clock;
	wire       snk_section_access_frame_start = frame_timing_start;
	reg  [7:0] rows [0:2];
	integer    n_fail = 0, checks = 0, i, k;
	always #50 mclk = ~mclk;
	suca_adapter dut_u (.*);
	suca_partner far_u (.*);
	task chk(input string name, input [7:0] seen, input [7:0] exp); begin
		checks = checks + 1;
		if (seen !== exp) begin
			n_fail = n_fail + 1;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	end endtask
	task frame; begin
		k = 0;
		@(negedge mclk);
		while (src_section_access_strobe !== 1'b1 && k < 12000) begin
			k = k + 1;
			@(negedge mclk);
		end
		if (k == 12000) n_fail = n_fail + 1;
	end endtask
	task end_of_test; begin
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end endtask
	initial begin
		#5000000;
		n_fail = n_fail + 1;
		end_of_test;
	end
	initial begin
		rows[0] = 8'h00;
		rows[1] = 8'hff;
		rows[2] = 8'h5a;
		repeat (3) @(negedge mclk);
		chk("reset ready", src_user_channel_ready, 1);
		chk("reset data", snk_user_channel_data, 8'hff);
		rst = 0;
		frame;
		for (i = 0; i < 3; i = i + 1) begin
			f1_octet = rows[i];
			src_user_channel_data = rows[i];
			src_user_channel_valid = 1;
			@(negedge mclk);
			src_user_channel_valid = 0;
			frame;
			chk("inserted", src_section_access_data, rows[i]);
			chk("extracted", snk_user_channel_data, rows[i]);
			chk("sink clock", snk_user_channel_clock, 1);
		end
		section_trail_fail = 1;
		@(negedge mclk);
		chk("fail flag", snk_user_channel_signal_fail, 1);
		chk("fail data", snk_user_channel_data, 8'hff);
		section_trail_fail = 0;
		@(negedge mclk);
		chk("flag clear", snk_user_channel_signal_fail, 0);
		chk("restored", snk_user_channel_data, rows[2]);
		src_user_channel_valid = 1;
		for (i = 0; i < 32; i = i + 1) begin
			src_user_channel_data = 8'h40 + i[7:0];
			@(negedge mclk);
		end
		src_user_channel_valid = 0;
		@(negedge mclk);
		chk("full ready", src_user_channel_ready, 0);
		frame;
		chk("fifo head", src_section_access_data, 8'h40);
		rst = 1;
		repeat (3) @(negedge mclk);
		rst = 0;
		chk("empty ready", src_user_channel_ready, 1);
		end_of_test;
	end
endmodule // suca_adapter_tb

/* File: tb/suca_partner.sv */
`timescale 1ns/1ps
module suca_partner (
	input  wire       mclk,
	input  wire [7:0] f1_octet,
	output reg        frame_timing_clock = 1'b0,
	output reg        frame_timing_start = 1'b0,
	output reg  [7:0] snk_section_access_data = 8'h00
);
	integer idx = 0;
	reg     phase = 1'b0;
	// Other bytes change every strobe, so a wrong byte position shows up.
	// The byte strobe runs at half rate and frame start rises one idle cycle early, which must be ignored.
	always @(negedge mclk) begin
		phase                   <= ~phase;
		frame_timing_clock      <= phase;
		frame_timing_start      <= idx == 0;
		snk_section_access_data <= idx == 270 ? f1_octet : ~idx[7:0];
		if (phase)
			idx <= idx == 2429 ? 0 : idx + 1;
	end
endmodule // suca_partner

/* File: verilog/suca_adapter.v */
// Contract
// RULE1: The source places each client user-channel octet, one per frame at 64 kbit/s, into the user-channel overhead byte of every frame it emits.
// RULE2: The sink takes the user-channel overhead byte out of each received frame and hands it to the client as an octet stream.
// RULE3: While the section trail fail input is high the sink raises its signal fail output and delivers all-ones within 1 ms.
// RULE4: When the alarm condition clears the sink returns to the extracted data within 1 ms.
// RULE5: The source gives the client a user-channel clock pulse once per frame, derived from the frame timing clock and start.
`timescale 1ns/1ps
`include "suca_defines.vh"

// ************************************************************
// Octet buffer
// ************************************************************
module suca_fifo #(
	parameter WIDTH = `SUCA_OCTET_WIDTH,
	parameter DEPTH = `SUCA_FIFO_DEPTH,
	parameter AW    = `SUCA_FIFO_AW
) (
	input  wire             mclk,
	input  wire             rst,
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output reg              in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	// One bit wider than the pointers, so a full buffer and an empty one read differently.
	reg [AW:0]      count;
	reg [AW:0]      next_count;
	wire            push;
	wire            pop;

	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always @* begin
		next_count = count;
		if (push & ~pop) begin
			next_count = count + {{AW{1'b0}}, 1'b1};
		end else if (pop & ~push) begin
			next_count = count - {{AW{1'b0}}, 1'b1};
		end
	end

	always @(posedge mclk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always @(posedge mclk) begin
		if (rst) begin
			wr_ptr   <= {AW{1'b0}};
			rd_ptr   <= {AW{1'b0}};
			count    <= {(AW+1){1'b0}};
			in_ready <= 1'b1;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
			end
			if (pop) begin
				rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
			end
			count    <= next_count;
			// Registered so the ready seen by the client never depends on its own valid.
			in_ready <= (next_count != DEPTH[AW:0]);
		end
	end
endmodule // suca_fifo

// ************************************************************
// User-channel adapter, source and sink
// ************************************************************
module suca_adapter (
	input  wire       mclk,
	input  wire       rst,
	input  wire [7:0] src_user_channel_data,
	input  wire       src_user_channel_valid,
	output wire       src_user_channel_ready,
	output reg        src_user_channel_clock,
	input  wire       frame_timing_clock,
	input  wire       frame_timing_start,
	output reg  [7:0] src_section_access_data,
	output reg        src_section_access_strobe,
	input  wire [7:0] snk_section_access_data,
	input  wire       snk_section_access_clock,
	input  wire       snk_section_access_frame_start,
	input  wire       section_trail_fail,
	output reg  [7:0] snk_user_channel_data,
	output reg        snk_user_channel_clock,
	output reg        snk_user_channel_signal_fail
);
	reg  [`SUCA_INDEX_WIDTH-1:0] src_count;
	wire [`SUCA_INDEX_WIDTH-1:0] src_index;
	reg  [`SUCA_INDEX_WIDTH-1:0] snk_count;
	wire [`SUCA_INDEX_WIDTH-1:0] snk_index;
	reg  [7:0]                   src_last;
	reg  [7:0]                   snk_capture;
	wire                         src_f1;
	wire                         snk_f1;
	reg                          src_locked;
	reg                          snk_locked;
	wire [7:0]                   fifo_data;
	wire                         fifo_valid;

	// ************************************************************
	// Source side
	// ************************************************************
	assign src_index = frame_timing_start ? {`SUCA_INDEX_WIDTH{1'b0}} : src_count;
	assign src_f1    = frame_timing_clock & src_locked & (src_index == `SUCA_F1_INDEX);

	// The buffer's own ready goes straight out, so what the client sees is exactly what the buffer takes.
	suca_fifo #(
		.WIDTH (`SUCA_OCTET_WIDTH),
		.DEPTH (`SUCA_FIFO_DEPTH),
		.AW    (`SUCA_FIFO_AW)
	) u_fifo (
		.mclk      (mclk),
		.rst       (rst),
		.in_data   (src_user_channel_data),
		.in_valid  (src_user_channel_valid),
		.in_ready  (src_user_channel_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (src_f1)
	);

	always @(posedge mclk) begin
		if (rst) begin
			src_count                 <= {`SUCA_INDEX_WIDTH{1'b0}};
			src_last                  <= `SUCA_RESET_OCTET;
			src_section_access_data   <= `SUCA_RESET_OCTET;
			src_section_access_strobe <= 1'b0;
			src_user_channel_clock    <= 1'b0;
		end else begin
			// The pulse leads the slot by 270 byte times, about a ninth of a frame, giving the client time to offer its octet.
			src_user_channel_clock    <= frame_timing_clock & frame_timing_start; // see RULE5
			src_section_access_strobe <= src_f1; // see RULE1
			if (frame_timing_clock) begin
				if (src_index == `SUCA_FRAME_BYTES - 12'd1) begin
					src_count <= {`SUCA_INDEX_WIDTH{1'b0}};
				end else begin
					src_count <= src_index + 12'd1;
				end
			end
			// An empty buffer at the slot repeats the last octet, as an octet slip would.
			if (src_f1) begin
				if (fifo_valid) begin
					src_section_access_data <= fifo_data; // see RULE1
					src_last                <= fifo_data;
				end else begin
					src_section_access_data <= src_last;
				end
			end
		end
	end

	// ************************************************************
	// Frame alignment
	// ************************************************************
	// Both byte counters start from zero at reset, which need not match
	// the frame phase of the incoming timing.
	// No slot is acted on until a frame start has been seen on that side,
	// so the first partial frame after reset neither inserts nor extracts
	// an octet at the wrong byte.
	always @(posedge mclk) begin
		if (rst) begin
			src_locked <= 1'b0;
			snk_locked <= 1'b0;
		end else begin
			if (frame_timing_clock & frame_timing_start) begin
				src_locked <= 1'b1;
			end
			if (snk_section_access_clock & snk_section_access_frame_start) begin
				snk_locked <= 1'b1;
			end
		end
	end

	// ************************************************************
	// Sink side
	// ************************************************************
	assign snk_index = snk_section_access_frame_start ? {`SUCA_INDEX_WIDTH{1'b0}} : snk_count;
	assign snk_f1    = snk_section_access_clock & snk_locked & (snk_index == `SUCA_F1_INDEX);

	always @(posedge mclk) begin
		if (rst) begin
			snk_count                    <= {`SUCA_INDEX_WIDTH{1'b0}};
			snk_capture                  <= `SUCA_RESET_OCTET;
			snk_user_channel_data        <= `SUCA_RESET_OCTET;
			snk_user_channel_clock       <= 1'b0;
			snk_user_channel_signal_fail <= 1'b0;
		end else begin
			if (snk_section_access_clock) begin
				if (snk_index == `SUCA_FRAME_BYTES - 12'd1) begin
					snk_count <= {`SUCA_INDEX_WIDTH{1'b0}};
				end else begin
					snk_count <= snk_index + 12'd1;
				end
			end
			// The capture holds the last extracted octet, so normal data returns right after the fail input drops.
			if (snk_f1) begin
				snk_capture <= snk_section_access_data; // see RULE2
			end
			snk_user_channel_clock       <= snk_f1; // see RULE2
			snk_user_channel_signal_fail <= section_trail_fail; // see RULE3
			// The fail input acts at once rather than at the next frame, well inside the allowed delay.
			if (section_trail_fail) begin
				snk_user_channel_data <= `SUCA_ALL_ONES; // see RULE3
			end else if (snk_f1) begin
				snk_user_channel_data <= snk_section_access_data; // see RULE2
			end else begin
				snk_user_channel_data <= snk_capture; // see RULE4
			end
		end
	end
endmodule // suca_adapter

/* File: verilog/suca_defines.vh */
`ifndef SUCA_DEFINES_VH
`define SUCA_DEFINES_VH

// ************************************************************
// Frame layout
// ************************************************************
`define SUCA_FRAME_BYTES  12'd2430
`define SUCA_F1_INDEX     12'd270
`define SUCA_INDEX_WIDTH  12

// ************************************************************
// Octet values and buffering
// ************************************************************
`define SUCA_ALL_ONES     8'hff
`define SUCA_RESET_OCTET  8'hff
`define SUCA_OCTET_WIDTH  8
`define SUCA_FIFO_DEPTH   32
`define SUCA_FIFO_AW      5

`endif
